/* File: core/ptt_pkg.sv */
// periodic tick timer: shared constants, register map and field layout
// assumes a 100 MHz aclk taken as the core input clock of the tick logic
//==========================================================================
// Overview of operation
// [RULE1] 11-bit modulus counter loaded from count field
// [RULE2] tick logic runs on core input clock
// [RULE3] divide clock by four after prescaling
// [RULE4] interrupt request each time counter reaches zero
// [RULE5] reload from bits 11..1, keep counting
// [RULE6] software changes count only while disabled
// [RULE7] tick replaces port b bit 8, level 4, mask bit1
// [RULE8] enabled timer silences port b bit 8 interrupts
// [RULE9] period is (count+1) times prescale times four
// [RULE10] bit 12 selects divide by 512 prescale
// [RULE11] bit 15 turns periodic timer on/off
// [RULE12] bits 14..13 read zero, ignore writes
// [RULE13] register access only in normal mode
// [RULE14] prescaler not cleared on enable
// [RULE15] exact spacing regardless of service latency
// [RULE16] disable halts; enable reloads counter first
package ptt_pkg;

    // register byte addresses
    localparam logic [11:0] PTT_CTRL_OFFSET   = 12'h0F0;
    localparam logic [11:0] PTT_STATUS_OFFSET = 12'h0F4;
    localparam logic [11:0] PTT_MASK_OFFSET   = 12'h0F8;
    localparam logic [11:0] PTT_COUNT_OFFSET  = 12'h0FC;

    // control register fields
    localparam int          PTT_EN_BIT        = 15;
    localparam int          PTT_PRE_BIT       = 12;
    localparam int          PTT_CNT_LSB       = 1;
    localparam int          PTT_CNT_W         = 11;
    localparam logic [15:0] PTT_CTRL_RESET    = 16'h0000;

    // interrupt status and mask layout, tick event sits at bit 1
    localparam int          PTT_EVT_BIT       = 1;

    // dividers
    localparam int          PTT_PRESCALE      = 512;
    localparam int          PTT_PRE_W         = 9;
    localparam int          PTT_DIV           = 4;
    localparam int          PTT_DIV_W         = 2;
    localparam logic [2:0]  PTT_IRQ_LEVEL     = 3'h4;

    // axi responses
    localparam logic [1:0]  PTT_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  PTT_RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        PTT_REG_CTRL,
        PTT_REG_STATUS,
        PTT_REG_MASK,
        PTT_REG_COUNT
    } ptt_reg_e;

endpackage

/* File: core/ptt_timer.sv */
// periodic tick timer with axi4-lite register slave
// assumes a single 100 MHz clock and a synchronous active-low reset
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps

module ptt_timer #(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              low_power_mode,
    input  wire logic              port_b_bit8_line,
    output logic                   irq,
    output logic [2:0]             irq_level
);

    //======================================================================
    // address decode
    //======================================================================

    // map a byte address to a register, flag unmapped ones
    function automatic logic decode(input logic [ADDR_W-1:0] addr, output ptt_pkg::ptt_reg_e sel);
        logic hit;
        hit = 1'b1;
        sel = ptt_pkg::PTT_REG_CTRL;
        if (addr == ADDR_W'(ptt_pkg::PTT_CTRL_OFFSET)) begin
            sel = ptt_pkg::PTT_REG_CTRL;
        end else if (addr == ADDR_W'(ptt_pkg::PTT_STATUS_OFFSET)) begin
            sel = ptt_pkg::PTT_REG_STATUS;
        end else if (addr == ADDR_W'(ptt_pkg::PTT_MASK_OFFSET)) begin
            sel = ptt_pkg::PTT_REG_MASK;
        end else if (addr == ADDR_W'(ptt_pkg::PTT_COUNT_OFFSET)) begin
            sel = ptt_pkg::PTT_REG_COUNT;
        end else begin
            hit = 1'b0;
        end
        return hit;
    endfunction

    //======================================================================
    // state
    //======================================================================

    logic                             ctrl_en;
    logic                             ctrl_pre;
    logic [ptt_pkg::PTT_CNT_W-1:0]    ctrl_cnt;
    logic                             stat_evt;
    logic                             mask_evt;
    logic                             aw_held;
    logic                             w_held;
    logic [ADDR_W-1:0]                aw_addr;
    logic [31:0]                      w_data;
    logic [3:0]                       w_strb;
    logic                             next_ctrl_en;
    logic                             next_ctrl_pre;
    logic [ptt_pkg::PTT_CNT_W-1:0]    next_ctrl_cnt;
    logic                             next_stat_evt;
    logic                             next_mask_evt;
    logic                             next_aw_held;
    logic                             next_w_held;
    logic [ADDR_W-1:0]                next_aw_addr;
    logic [31:0]                      next_w_data;
    logic [3:0]                       next_w_strb;
    logic                             next_bvalid;
    logic [1:0]                       next_bresp;
    logic                             next_rvalid;
    logic [1:0]                       next_rresp;
    logic [31:0]                      next_rdata;
    logic                             next_irq;

    logic                             run;
    logic [ptt_pkg::PTT_PRE_W-1:0]    pre_cnt;
    logic [ptt_pkg::PTT_DIV_W-1:0]    div_cnt;
    logic [ptt_pkg::PTT_CNT_W-1:0]    mod_cnt;
    logic                             tick_evt;
    logic                             next_run;
    logic [ptt_pkg::PTT_PRE_W-1:0]    next_pre_cnt;
    logic [ptt_pkg::PTT_DIV_W-1:0]    next_div_cnt;
    logic [ptt_pkg::PTT_CNT_W-1:0]    next_mod_cnt;
    logic                             next_tick_evt;

    //======================================================================
    // tick counter
    //======================================================================

    // prescale, divide by four, count down, reload at zero
    always_comb begin
        logic pre_step;
        pre_step      = 1'b0;
        next_run      = run;
        next_pre_cnt  = pre_cnt;
        next_div_cnt  = div_cnt;
        next_mod_cnt  = mod_cnt;
        next_tick_evt = 1'b0;
        if (!ctrl_en) begin
            next_run = 1'b0;                                        // [RULE16]
        end else if (!run) begin
            next_run     = 1'b1;
            next_mod_cnt = ctrl_cnt;                                // [RULE16]
        end else begin
            if (ctrl_pre) begin
                // counts only while running, never cleared on enable
                next_pre_cnt = pre_cnt + 1'b1;                      // [RULE14]
                pre_step     = (pre_cnt == ptt_pkg::PTT_PRE_W'(ptt_pkg::PTT_PRESCALE - 1)); // [RULE10]
            end else begin
                pre_step = 1'b1;                                    // [RULE10]
            end
            if (pre_step) begin
                next_div_cnt = div_cnt + 1'b1;                      // [RULE3]
                if (div_cnt == ptt_pkg::PTT_DIV_W'(ptt_pkg::PTT_DIV - 1)) begin
                    if (mod_cnt == '0) begin
                        next_tick_evt = 1'b1;                       // [RULE4]
                        next_mod_cnt  = ctrl_cnt;                   // [RULE5] [RULE9] [RULE15]
                    end else begin
                        next_mod_cnt = mod_cnt - 1'b1;              // [RULE1]
                    end
                end
            end
        end
    end

    // tick counter registers, all on the core input clock
    always_ff @(posedge aclk) begin                                 // [RULE2]
        if (!aresetn) begin
            run      <= 1'b0;
            pre_cnt  <= '0;
            div_cnt  <= '0;
            mod_cnt  <= '0;
            tick_evt <= 1'b0;
        end else begin
            run      <= next_run;
            pre_cnt  <= next_pre_cnt;
            div_cnt  <= next_div_cnt;
            mod_cnt  <= next_mod_cnt;
            tick_evt <= next_tick_evt;
        end
    end

    //======================================================================
    // register slave and interrupt
    //======================================================================

    // bus handshakes, register writes, reads and interrupt status
    always_comb begin
        logic     hit;
        logic     src_evt;
        ptt_pkg::ptt_reg_e sel;
        logic [15:0] ctrl_rd;
        hit           = 1'b0;
        src_evt       = 1'b0;
        sel           = ptt_pkg::PTT_REG_CTRL;
        next_ctrl_en  = ctrl_en;
        next_ctrl_pre = ctrl_pre;
        next_ctrl_cnt = ctrl_cnt;
        next_stat_evt = stat_evt;
        next_mask_evt = mask_evt;
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_aw_addr  = aw_addr;
        next_w_data   = w_data;
        next_w_strb   = w_strb;
        next_bvalid   = s_axi_bvalid;
        next_bresp    = s_axi_bresp;
        next_rvalid   = s_axi_rvalid;
        next_rresp    = s_axi_rresp;
        next_rdata    = s_axi_rdata;
        // bits 14..13 and bit 0 always zero
        ctrl_rd = {ctrl_en, 2'b00, ctrl_pre, ctrl_cnt, 1'b0};      // [RULE12]
        // capture address and data independently
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // perform the write once both halves are held
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            hit          = decode(aw_addr, sel);
            if (!hit || low_power_mode) begin
                next_bresp = ptt_pkg::PTT_RESP_SLVERR;              // [RULE13]
            end else begin
                next_bresp = ptt_pkg::PTT_RESP_OKAY;
                unique case (sel)
                    ptt_pkg::PTT_REG_CTRL: begin
                        if (w_strb[1]) begin
                            next_ctrl_en  = w_data[ptt_pkg::PTT_EN_BIT];    // [RULE11]
                            next_ctrl_pre = w_data[ptt_pkg::PTT_PRE_BIT];   // [RULE10]
                        end
                        // count is locked while the timer runs
                        if (!ctrl_en) begin                         // [RULE6]
                            if (w_strb[0]) begin
                                next_ctrl_cnt[6:0] = w_data[7:1];
                            end
                            if (w_strb[1]) begin
                                next_ctrl_cnt[10:7] = w_data[11:8];
                            end
                        end
                    end
                    ptt_pkg::PTT_REG_STATUS: begin
                        if (w_strb[0] && w_data[ptt_pkg::PTT_EVT_BIT]) begin
                            next_stat_evt = 1'b0;
                        end
                    end
                    ptt_pkg::PTT_REG_MASK: begin
                        if (w_strb[0]) begin
                            next_mask_evt = w_data[ptt_pkg::PTT_EVT_BIT];   // [RULE7]
                        end
                    end
                    ptt_pkg::PTT_REG_COUNT: begin
                    end
                endcase
            end
        end
        // tick replaces port b bit 8 as the source while enabled
        src_evt = ctrl_en ? tick_evt : port_b_bit8_line;            // [RULE8] [RULE7]
        if (src_evt) begin
            next_stat_evt = 1'b1;                                   // [RULE4]
        end
        // read channel
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = '0;
            hit         = decode(s_axi_araddr, sel);
            if (!hit || low_power_mode) begin
                next_rresp = ptt_pkg::PTT_RESP_SLVERR;              // [RULE13]
            end else begin
                next_rresp = ptt_pkg::PTT_RESP_OKAY;
                unique case (sel)
                    ptt_pkg::PTT_REG_CTRL:   next_rdata[15:0] = ctrl_rd;
                    ptt_pkg::PTT_REG_STATUS: next_rdata[ptt_pkg::PTT_EVT_BIT] = stat_evt;
                    ptt_pkg::PTT_REG_MASK:   next_rdata[ptt_pkg::PTT_EVT_BIT] = mask_evt;
                    ptt_pkg::PTT_REG_COUNT:  next_rdata[ptt_pkg::PTT_CNT_W-1:0] = mod_cnt;
                endcase
            end
        end
        next_irq = next_stat_evt && next_mask_evt;                  // [RULE7]
    end

    // slave and register flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_en       <= ptt_pkg::PTT_CTRL_RESET[ptt_pkg::PTT_EN_BIT];
            ctrl_pre      <= ptt_pkg::PTT_CTRL_RESET[ptt_pkg::PTT_PRE_BIT];
            ctrl_cnt      <= ptt_pkg::PTT_CTRL_RESET[11:1];
            stat_evt      <= 1'b0;
            mask_evt      <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= ptt_pkg::PTT_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= ptt_pkg::PTT_RESP_OKAY;
            s_axi_rdata   <= '0;
            irq           <= 1'b0;
            irq_level     <= 3'h0;
        end else begin
            ctrl_en       <= next_ctrl_en;
            ctrl_pre      <= next_ctrl_pre;
            ctrl_cnt      <= next_ctrl_cnt;
            stat_evt      <= next_stat_evt;
            mask_evt      <= next_mask_evt;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= !next_aw_held;
            s_axi_wready  <= !next_w_held;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rresp   <= next_rresp;
            s_axi_rdata   <= next_rdata;
            irq           <= next_irq;
            irq_level     <= ptt_pkg::PTT_IRQ_LEVEL;                // [RULE7]
        end
    end

endmodule

/* File: sim/ptt_intc_model.sv */
// interrupt controller stand-in: times tick requests, drives port b line
// assumes irq is a level held until software clears the status bit
`timescale 1ns/1ps
module ptt_intc_model (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   irq,
    input  wire logic   pulse_req,
    output logic        port_b_bit8_line,
    output logic [31:0] gap
);
    logic [31:0] cnt;
    logic        irq_q;
    //======================================================================
    // request spacing and port b pulses
    // rise-to-rise cycle count, one-cycle pulse per bench request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt              <= 32'h0;
            irq_q            <= 1'b0;
            gap              <= 32'h0;
            port_b_bit8_line <= 1'b0;
        end else begin
            irq_q            <= irq;
            port_b_bit8_line <= pulse_req;
            cnt              <= (irq && !irq_q) ? 32'h1 : cnt + 32'h1;
            if (irq && !irq_q) begin
                gap <= cnt;
            end
        end
    end
endmodule

/* File: sim/ptt_timer_sva.sv */
// checker for the tick timer register slave and interrupt level
// assumes it is bound to ptt_timer and sees only its ports
`timescale 1ns/1ps
module ptt_timer_sva #(
    parameter int ADDR_W = 12
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              low_power_mode,
    input wire logic [2:0]        irq_level
);
    //======================================================================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic ar_ok;
    logic wr_go;
    // handshake qualifiers
    assign ar_ok = s_axi_arvalid && s_axi_arready;
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    level_fixed_a: assert property ($past(aresetn, 2) |-> irq_level == 3'h4)
        else $error("irq level not four");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open during answer");
    wr_answer_a: assert property (wr_go |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer timing");
    rd_answer_a: assert property (ar_ok |=> s_axi_rvalid)
        else $error("read answer timing");
    lp_read_a: assert property (ar_ok && low_power_mode |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("low power read not refused");
    ctrl_rsvd_a: assert property (ar_ok && s_axi_araddr == 12'h0F0 |=>
        {s_axi_rdata[31:16], s_axi_rdata[14:13], s_axi_rdata[0]} == 19'h0)
        else $error("reserved control bits set");
    cover property (wr_go && low_power_mode);
    cover property (s_axi_bvalid && !s_axi_bready);
    cover property (ar_ok && s_axi_araddr == 12'h0F0);
endmodule

bind ptt_timer ptt_timer_sva #(.ADDR_W(ADDR_W)) sva_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .low_power_mode(low_power_mode),
    .irq_level(irq_level));

/* File: sim/periodic_tick_timer_bench.sv */
// self-checking bench for the tick timer over axi4-lite
// assumes ptt_timer, ptt_pkg and the interrupt controller model
`timescale 1ns/1ps
module periodic_tick_timer_bench;
    localparam logic [11:0] C  = ptt_pkg::PTT_CTRL_OFFSET;
    localparam logic [11:0] S  = ptt_pkg::PTT_STATUS_OFFSET;
    localparam logic [11:0] M  = ptt_pkg::PTT_MASK_OFFSET;
    localparam logic [11:0] K  = ptt_pkg::PTT_COUNT_OFFSET;
    localparam logic [1:0]  OK = ptt_pkg::PTT_RESP_OKAY;
    localparam logic [1:0]  ER = ptt_pkg::PTT_RESP_SLVERR;
    localparam logic [31:0] P3 = 32'(ptt_pkg::PTT_DIV * 4);
    localparam logic [31:0] PP = 32'(ptt_pkg::PTT_PRESCALE * ptt_pkg::PTT_DIV);
    logic        aclk = 1'b0, aresetn = 1'b0, lpm = 1'b0, pulse = 1'b0, pb8, irq;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, gap, v;
    logic [1:0]  bresp, rresp, rs;
    logic [2:0]  lvl;
    int          error_cnt = 0, num_checks = 0;
    //======================================================================
    // clock, design and far side
    always #5 aclk = ~aclk;
    ptt_timer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_power_mode(lpm),
        .port_b_bit8_line(pb8), .irq(irq), .irq_level(lvl));
    ptt_intc_model far_u (.aclk(aclk), .aresetn(aresetn), .irq(irq), .pulse_req(pulse),
        .port_b_bit8_line(pb8), .gap(gap));
    //======================================================================
    // compare, verdict and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic fail();
        error_cnt++;
        end_sim();
    endtask
    // write word, wait for answer, check response
    task automatic wc(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 99);
        if (n >= 99) fail();
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    // read word into v and rs
    task automatic rr(input logic [11:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 99);
        if (n >= 99) fail();
        v = rdata;
        rs = rresp;
        rready <= 1'b1;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        rr(a);
        chk(v, ed);
        chk({30'h0, rs}, {30'h0, er});
    endtask
    // bounded wait for the interrupt level
    task automatic wirq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 9999) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 9999) fail();
    endtask
    // spacing of two ticks, second clear served late
    task automatic meas(input int late, input logic [31:0] exp);
        wc(S, 32'h2, OK);
        wirq();
        repeat (late) @(posedge aclk);
        wc(S, 32'h2, OK);
        wirq();
        @(posedge aclk);
        chk(gap, exp);
    endtask
    //======================================================================
    // main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rc(C, 32'h0, OK);
        chk({31'h0, irq}, 32'h0);
        chk({29'h0, lvl}, 32'h4);
        wc(C, 32'h7FFF, OK);
        rc(C, 32'h1FFE, OK);
        wc(M, 32'h2, OK);
        wc(C, 32'h8006, OK);
        meas(0, P3);
        meas(6, P3);
        wc(C, 32'h800A, OK);
        rc(C, 32'h8006, OK);
        wc(C, 32'h0, OK);
        wc(C, 32'h9FFE, OK);
        wc(S, 32'h2, OK);
        pulse <= 1'b1;
        @(posedge aclk);
        pulse <= 1'b0;
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wc(C, 32'h1FFE, OK);
        rr(K);
        repeat (20) @(posedge aclk);
        rc(K, v, OK);
        pulse <= 1'b1;
        @(posedge aclk);
        pulse <= 1'b0;
        wirq();
        rc(S, 32'h2, OK);
        wc(M, 32'h0, OK);
        chk({31'h0, irq}, 32'h0);
        lpm <= 1'b1;
        wc(C, 32'h8000, ER);
        rc(C, 32'h0, ER);
        lpm <= 1'b0;
        rc(C, 32'h1FFE, OK);
        rc(12'h100, 32'h0, ER);
        wc(M, 32'h2, OK);
        wc(C, 32'h1000, OK);
        wc(C, 32'h9000, OK);
        meas(0, PP);
        end_sim();
    end
endmodule
